//--- logic/cfa_pkg.sv
// package for the condition-flag and operand-formatting block
// assumes a single 10 MHz core clock and an APB register port
package cfa_pkg;
    // ------------------------------------------------------------
    // flag bit positions
    // ------------------------------------------------------------
    localparam int SIGN_BIT  = 7;
    localparam int ZERO_BIT  = 6;
    localparam int HALF_BIT  = 4;
    localparam int PV_BIT    = 2;
    localparam int NSUB_BIT  = 1;
    localparam int CARRY_BIT = 0;
    localparam logic [7:0] FLAG_USED_MASK = 8'hd7;
    localparam logic [7:0] FLAG_RESET     = 8'h00;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_FLAGS     = 8'h00; // condition_flags
    localparam logic [7:0] OFF_ALT_FLAGS = 8'h04; // alternate copy
    localparam logic [7:0] OFF_OPERANDS  = 8'h08; // {cmd, aux, b, a}
    localparam logic [7:0] OFF_RESULT    = 8'h0c; // {0, result}
    localparam logic [7:0] OFF_INSTR     = 8'h10; // instruction bytes 1..4
    localparam logic [7:0] OFF_PAIR      = 8'h14; // {second reg, first reg}
    localparam logic [7:0] OFF_ADDR      = 8'h18; // {target, operand addr}
    localparam logic [7:0] OFF_INFO      = 8'h1c; // decode info
    localparam logic [7:0] OFF_CONTROL   = 8'h20; // write-only actions

    // ------------------------------------------------------------
    // operation codes written to the command byte
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        OP_NONE, OP_ADD, OP_ADC, OP_SUB, OP_SBC, OP_AND, OP_OR, OP_XOR,
        OP_CMP, OP_ROTL, OP_ROTR, OP_BIT, OP_INPUT, OP_BLOCKIO,
        OP_FORCE_CARRY, OP_INVERT_CARRY
    } cfa_op_t;

    // decimal adjust is a control-register action, see bit 0
    localparam int CTRL_DEC_ADJ_BIT = 0;
    localparam int CTRL_SWAP_BIT = 1;

    // ------------------------------------------------------------
    // carried values
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] result;
        logic [7:0] flags;
        logic       update;
    } cfa_alu_t;

    typedef struct packed {
        logic [15:0] operand_addr;
        logic [15:0] branch_target;
        logic [15:0] restart_target;
        logic [15:0] imm16;
        logic [2:0]  reg_field;
    } cfa_fmt_t;
endpackage

//--- logic/cfa_core.sv
// condition-flag generation and operand/instruction formatting
// assumes an APB master on core_clk; no other clock and no interrupts
//
// Operation
// - instructions of one to four bytes
// - multi-byte data least significant byte first
// - direct address: byte 2 low, byte 3 high
// - register chosen by two or three bit field
// - indirect: first register high, second low
// - immediate 8 or 16 bits, low byte first
// - branch target from bytes or register pair
// - restart goes to eight times vector field
// - flag layout S Z - H - PV N C, alternate copy
// - carry, parity, zero, sign are testable
// - carry from add carry or subtract borrow
// - rotates: carry gets bit 7 or bit 0
// - logic ops clear carry; set and invert carry
// - add clears N, subtract sets N
// - overflow when sign carry in differs out
// - parity one for even count of ones
// - half carry from bit 3 into 4
// - zero set when result is zero
// - compare subtracts without changing accumulator
// - bit test loads zero with inverse bit
// - block io zero when counter minus one zero
// - sign copies result bit 7
//
// Implementation choices: the placing of the registers and the APB register port.
`timescale 1ns/100ps
module cfa_core (
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        arst_n,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // condition evaluation for branches
    input  wire logic [2:0]  cond_sel,
    output logic             cond_true
);
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic even_parity(input logic [7:0] v);
        return ~^v;
    endfunction

    function automatic logic [15:0] join16(input logic [7:0] lo, input logic [7:0] hi);
        return {hi, lo};
    endfunction

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [7:0]  flags;
    logic [7:0]  alt_flags;
    logic [7:0]  opa;
    logic [7:0]  opb;
    logic [7:0]  aux;
    logic [7:0]  result;
    logic [31:0] instr;
    logic [15:0] pair;

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    wire wr_en   = psel & penable & pwrite;
    wire hit_fl  = paddr == cfa_pkg::OFF_FLAGS;
    wire hit_alt = paddr == cfa_pkg::OFF_ALT_FLAGS;
    wire hit_op  = paddr == cfa_pkg::OFF_OPERANDS;
    wire hit_res = paddr == cfa_pkg::OFF_RESULT;
    wire hit_ins = paddr == cfa_pkg::OFF_INSTR;
    wire hit_par = paddr == cfa_pkg::OFF_PAIR;
    wire hit_adr = paddr == cfa_pkg::OFF_ADDR;
    wire hit_inf = paddr == cfa_pkg::OFF_INFO;
    wire hit_ctl = paddr == cfa_pkg::OFF_CONTROL;
    wire mapped  = hit_fl | hit_alt | hit_op | hit_res | hit_ins | hit_par
                 | hit_adr | hit_inf | hit_ctl;
    wire cmd_go  = wr_en & hit_op;
    wire dec_adj_go = wr_en & hit_ctl & pwdata[cfa_pkg::CTRL_DEC_ADJ_BIT];
    wire swap_go = wr_en & hit_ctl & pwdata[cfa_pkg::CTRL_SWAP_BIT];

    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~mapped;

    // ------------------------------------------------------------
    // flag arithmetic for the commanded operation
    // ------------------------------------------------------------
    cfa_pkg::cfa_op_t op;
    assign op = cfa_pkg::cfa_op_t'(pwdata[27:24]);
    wire [7:0] wa = pwdata[7:0];
    wire [7:0] wb = pwdata[15:8];
    wire [7:0] wx = pwdata[23:16];
    wire       cin_old = flags[cfa_pkg::CARRY_BIT];

    wire       is_sub  = op == cfa_pkg::OP_SUB || op == cfa_pkg::OP_SBC
                      || op == cfa_pkg::OP_CMP;
    wire       use_c   = (op == cfa_pkg::OP_ADC || op == cfa_pkg::OP_SBC) & cin_old;
    // subtract is done as add of the complement; borrow is the inverted carry
    wire [7:0] addend  = is_sub ? ~wb : wb;
    wire       cin     = is_sub ? ~use_c : use_c;
    wire [4:0] low_sum = {1'b0, wa[3:0]} + {1'b0, addend[3:0]} + {4'h0, cin};
    wire [7:0] low7    = {1'b0, wa[6:0]} + {1'b0, addend[6:0]} + {7'h00, cin};
    wire [8:0] sum     = {1'b0, wa} + {1'b0, addend} + {8'h00, cin};
    wire       c_into7 = low7[7];
    wire       carry_o = is_sub ? ~sum[8] : sum[8];
    wire       half_o  = is_sub ? ~low_sum[4] : low_sum[4];
    wire       ovf_o   = c_into7 ^ sum[8];

    cfa_pkg::cfa_alu_t alu;
    always_comb begin
        alu.result = wa;
        alu.flags  = flags;
        alu.update = 1'b1;
        case (op)
            cfa_pkg::OP_ADD, cfa_pkg::OP_ADC, cfa_pkg::OP_SUB, cfa_pkg::OP_SBC,
            cfa_pkg::OP_CMP: begin
                // compare keeps the accumulator value as its result
                alu.result = (op == cfa_pkg::OP_CMP) ? wa : sum[7:0];
                alu.flags[cfa_pkg::CARRY_BIT] = carry_o;
                alu.flags[cfa_pkg::NSUB_BIT]  = is_sub;
                alu.flags[cfa_pkg::PV_BIT]    = ovf_o;
                alu.flags[cfa_pkg::HALF_BIT]  = half_o;
                alu.flags[cfa_pkg::ZERO_BIT]  = sum[7:0] == 8'h00;
                alu.flags[cfa_pkg::SIGN_BIT]  = sum[7];
            end
            cfa_pkg::OP_AND, cfa_pkg::OP_OR, cfa_pkg::OP_XOR: begin
                if (op == cfa_pkg::OP_AND) begin
                    alu.result = wa & wb;
                end else if (op == cfa_pkg::OP_OR) begin
                    alu.result = wa | wb;
                end else begin
                    alu.result = wa ^ wb;
                end
                alu.flags[cfa_pkg::CARRY_BIT] = 1'b0;
                alu.flags[cfa_pkg::NSUB_BIT]  = 1'b0;
                alu.flags[cfa_pkg::HALF_BIT]  = op == cfa_pkg::OP_AND;
                alu.flags[cfa_pkg::PV_BIT]    = even_parity(alu.result);
                alu.flags[cfa_pkg::ZERO_BIT]  = alu.result == 8'h00;
                alu.flags[cfa_pkg::SIGN_BIT]  = alu.result[7];
            end
            cfa_pkg::OP_ROTL, cfa_pkg::OP_ROTR: begin
                // aux bit 0 selects rotate through carry
                if (op == cfa_pkg::OP_ROTL) begin
                    alu.result = {wa[6:0], wx[0] ? cin_old : wa[7]};
                    alu.flags[cfa_pkg::CARRY_BIT] = wa[7];
                end else begin
                    alu.result = {wx[0] ? cin_old : wa[0], wa[7:1]};
                    alu.flags[cfa_pkg::CARRY_BIT] = wa[0];
                end
                alu.flags[cfa_pkg::NSUB_BIT] = 1'b0;
                alu.flags[cfa_pkg::HALF_BIT] = 1'b0;
                alu.flags[cfa_pkg::PV_BIT]   = even_parity(alu.result);
                alu.flags[cfa_pkg::ZERO_BIT] = alu.result == 8'h00;
                alu.flags[cfa_pkg::SIGN_BIT] = alu.result[7];
            end
            cfa_pkg::OP_BIT: begin
                // aux[2:0] names the tested bit of operand a
                alu.flags[cfa_pkg::ZERO_BIT] = ~wa[wx[2:0]];
                alu.flags[cfa_pkg::HALF_BIT] = 1'b1;
                alu.flags[cfa_pkg::NSUB_BIT] = 1'b0;
            end
            cfa_pkg::OP_INPUT: begin
                // register_input_op: a is the received byte
                alu.flags[cfa_pkg::ZERO_BIT] = wa == 8'h00;
                alu.flags[cfa_pkg::SIGN_BIT] = wa[7];
                alu.flags[cfa_pkg::PV_BIT]   = even_parity(wa);
                alu.flags[cfa_pkg::HALF_BIT] = 1'b0;
                alu.flags[cfa_pkg::NSUB_BIT] = 1'b0;
            end
            cfa_pkg::OP_BLOCKIO: begin
                // b is the byte counter before the transfer
                alu.result = wb - 8'h01;
                alu.flags[cfa_pkg::ZERO_BIT] = (wb - 8'h01) == 8'h00;
                alu.flags[cfa_pkg::NSUB_BIT] = 1'b1;
            end
            cfa_pkg::OP_FORCE_CARRY: begin
                alu.flags[cfa_pkg::CARRY_BIT] = 1'b1;
                alu.flags[cfa_pkg::NSUB_BIT]  = 1'b0;
                alu.flags[cfa_pkg::HALF_BIT]  = 1'b0;
            end
            cfa_pkg::OP_INVERT_CARRY: begin
                alu.flags[cfa_pkg::CARRY_BIT] = ~cin_old;
                alu.flags[cfa_pkg::NSUB_BIT]  = 1'b0;
                alu.flags[cfa_pkg::HALF_BIT]  = cin_old;
            end
            default: begin
                alu.update = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------
    // decimal adjust of the stored result
    // ------------------------------------------------------------
    wire       da_lo   = flags[cfa_pkg::HALF_BIT] | (result[3:0] > 4'h9);
    wire       da_hi   = flags[cfa_pkg::CARRY_BIT] | (result > 8'h99);
    wire [7:0] da_corr = {da_hi ? 4'h6 : 4'h0, da_lo ? 4'h6 : 4'h0};
    wire       da_sub  = flags[cfa_pkg::NSUB_BIT];
    wire [7:0] da_res  = da_sub ? result - da_corr : result + da_corr;
    wire [7:0] da_flags;
    assign da_flags = {da_res[7], da_res == 8'h00, 1'b0,
                       da_sub ? (flags[cfa_pkg::HALF_BIT] & ~da_lo)
                              : (result[3:0] > 4'h9),
                       1'b0, even_parity(da_res), da_sub, da_hi};

    // ------------------------------------------------------------
    // flag and operand registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            flags     <= cfa_pkg::FLAG_RESET;
            alt_flags <= cfa_pkg::FLAG_RESET;
        end else if (swap_go) begin
            flags     <= alt_flags;
            alt_flags <= flags;
        end else if (dec_adj_go) begin
            flags     <= da_flags & cfa_pkg::FLAG_USED_MASK;
        end else if (cmd_go && alu.update) begin
            flags     <= alu.flags & cfa_pkg::FLAG_USED_MASK;
        end else if (wr_en && hit_fl) begin
            flags     <= pwdata[7:0] & cfa_pkg::FLAG_USED_MASK;
        end else if (wr_en && hit_alt) begin
            alt_flags <= pwdata[7:0] & cfa_pkg::FLAG_USED_MASK;
        end
    end

    // operand capture and result
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            opa    <= 8'h00;
            opb    <= 8'h00;
            aux    <= 8'h00;
            result <= 8'h00;
        end else if (cmd_go) begin
            opa    <= wa;
            opb    <= wb;
            aux    <= wx;
            result <= alu.result;
        end else if (dec_adj_go) begin
            result <= da_res;
        end
    end

    // instruction bytes and register pair
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            instr <= 32'h0000_0000;
            pair  <= 16'h0000;
        end else if (wr_en && hit_ins) begin
            instr <= pwdata;
        end else if (wr_en && hit_par) begin
            pair  <= pwdata[15:0];
        end
    end

    // ------------------------------------------------------------
    // instruction formatting; byte 1 is the opcode at lowest address
    // ------------------------------------------------------------
    wire [7:0] byte1 = instr[7:0];
    wire [7:0] byte2 = instr[15:8];
    wire [7:0] byte3 = instr[23:16];
    // pair register: [7:0] first register, [15:8] second register
    wire [15:0] pair_addr = join16(pair[15:8], pair[7:0]);

    cfa_pkg::cfa_fmt_t fmt;
    // direct address and 16-bit immediate share one word: byte 2 low, byte 3 high
    assign fmt.operand_addr   = byte1[0] ? pair_addr : fmt.imm16;
    assign fmt.branch_target  = byte1[1] ? pair_addr : join16(byte2, byte3);
    assign fmt.restart_target = {10'h000, byte1[5:3], 3'h0};
    assign fmt.imm16          = join16(byte2, byte3);
    // two-bit pair field or three-bit register field
    assign fmt.reg_field      = byte1[2] ? {1'b0, byte1[5:4]} : byte1[5:3];

    // ------------------------------------------------------------
    // condition test; only C, PV, Z and S are reachable
    // ------------------------------------------------------------
    logic cond_flag;
    always_comb begin
        case (cond_sel[2:1])
            2'd0:    cond_flag = flags[cfa_pkg::ZERO_BIT];
            2'd1:    cond_flag = flags[cfa_pkg::CARRY_BIT];
            2'd2:    cond_flag = flags[cfa_pkg::PV_BIT];
            default: cond_flag = flags[cfa_pkg::SIGN_BIT];
        endcase
    end
    assign cond_true = cond_flag ^ ~cond_sel[0];

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    logic [31:0] rd;
    always_comb begin
        rd = 32'h0000_0000;
        if (hit_fl)  rd = {24'h000000, flags};
        if (hit_alt) rd = {24'h000000, alt_flags};
        if (hit_op)  rd = {8'h00, aux, opb, opa};
        if (hit_res) rd = {24'h000000, result};
        if (hit_ins) rd = instr;
        if (hit_par) rd = {16'h0000, pair};
        if (hit_adr) rd = {fmt.branch_target, fmt.operand_addr};
        if (hit_inf) rd = {fmt.restart_target, byte2, 5'h00, fmt.reg_field};
    end
    assign prdata = rd;
endmodule

//--- bench/cfa_core_properties.sv
// checker for the flag and operand-formatting block
// assumes only the top module's ports; bound from the foot of this file
`timescale 1ns/100ps
module cfa_props (
    // clock and reset
    input wire logic        core_clk,
    input wire logic        arst_n,
    // apb slave
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // condition evaluation
    input wire logic [2:0]  cond_sel,
    input wire logic        cond_true
);
    // ------------------------------------------------------------
    // shadows of the formatting inputs, taken from completed writes
    // ------------------------------------------------------------
    logic [31:0] instr_q;
    logic [15:0] pair_q;
    wire wr_acc = psel && penable && pwrite;
    wire unmapped = paddr > cfa_pkg::OFF_CONTROL;
    wire [15:0] pair_addr = {pair_q[7:0], pair_q[15:8]};
    // condition bit picked the same way the branch logic must pick it
    wire cflag = cond_sel[2] ? (cond_sel[1] ? prdata[7] : prdata[2])
                             : (cond_sel[1] ? prdata[0] : prdata[6]);
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) instr_q <= 32'h0;
        else if (wr_acc && paddr == cfa_pkg::OFF_INSTR) instr_q <= pwdata;
    end
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) pair_q <= 16'h0;
        else if (wr_acc && paddr == cfa_pkg::OFF_PAIR) pair_q <= pwdata[15:0];
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_ready_zero_wait: assert property (psel |-> pready)
        else $error("slave inserted a wait state");
    a_unmapped_error: assert property (psel && penable && unmapped |-> pslverr && prdata == 0)
        else $error("unmapped access not refused");
    a_mapped_no_error: assert property (psel && penable && !unmapped && paddr[1:0] == 0 |-> !pslverr)
        else $error("mapped access refused");
    a_flag_unused_bits: assert property (psel && paddr == 0 |-> (prdata & ~32'hd7) == 0)
        else $error("unused flag bits not zero");
    a_flag_write_seen: assert property (wr_acc && paddr == 0
        ##2 psel && !penable && paddr == 0
        |-> prdata[7:0] == ($past(pwdata[7:0], 2) & cfa_pkg::FLAG_USED_MASK))
        else $error("flag write not visible");
    a_cond_match: assert property (psel && paddr == 0
        |-> cond_true == (cflag == cond_sel[0]))
        else $error("condition result wrong");
    a_restart_vector: assert property (psel && paddr == cfa_pkg::OFF_INFO
        |-> prdata[31:16] == {10'h0, instr_q[5:3], 3'h0})
        else $error("restart target wrong");
    a_reg_field_sel: assert property (psel && paddr == cfa_pkg::OFF_INFO
        |-> prdata[2:0] == (instr_q[2] ? {1'b0, instr_q[5:4]} : instr_q[5:3]))
        else $error("register field wrong");
    a_direct_addr: assert property (psel && paddr == cfa_pkg::OFF_ADDR && !instr_q[0]
        |-> prdata[15:0] == instr_q[23:8])
        else $error("direct address wrong");
    a_indirect_addr: assert property (psel && paddr == cfa_pkg::OFF_ADDR && instr_q[0]
        |-> prdata[15:0] == pair_addr)
        else $error("indirect address wrong");
    a_branch_target: assert property (psel && paddr == cfa_pkg::OFF_ADDR
        |-> prdata[31:16] == (instr_q[1] ? pair_addr : instr_q[23:8]))
        else $error("branch target wrong");
    c_flag_write: cover property (wr_acc && paddr == 0);
    c_unmapped: cover property (psel && penable && unmapped);
    c_short_field: cover property (psel && paddr == cfa_pkg::OFF_INFO && instr_q[2]);
endmodule
bind cfa_core cfa_props u_props (.core_clk(core_clk), .arst_n(arst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cond_sel(cond_sel), .cond_true(cond_true));

//--- bench/cfa_core_tb.sv
// self-checking bench for the flag and operand-formatting block
// assumes the apb slave answers without wait states; one clock
`timescale 1ns/100ps
module cfa_core_tb;
    logic        core_clk = 0;
    logic        arst_n = 0;
    logic        psel = 0;
    logic        penable = 0;
    logic        pwrite = 0;
    logic [7:0]  paddr = 0;
    logic [31:0] pwdata = 0;
    logic [2:0]  cond_sel = 0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        cond_true;
    logic [31:0] rd;
    logic        err;
    logic [7:0]  fv;
    int          error_cnt = 0;
    int          checks_done = 0;
    int          cycles = 0;
    localparam int FIDX[4] = '{6, 0, 2, 7};

    cfa_core dut (.core_clk(core_clk), .arst_n(arst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cond_sel(cond_sel), .cond_true(cond_true));

    // ------------------------------------------------------------
    // clock and hang guard
    // ------------------------------------------------------------
    initial begin
        forever #50 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 5000) begin
            error_cnt++;
            $display("ERROR at %0t: timeout", $time);
            summarize();
        end
    end

    // one apb transfer; an idle cycle follows so psel never toggles twice in one step
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1) @(posedge core_clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
        checks_done++;
        if ((got & m) !== exp) begin
            error_cnt++;
            $display("ERROR at %0t: got %h expected %h", $time, got & m, exp);
        end
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
        xfer(1'b0, a, 32'h0);
        chk(rd, exp, m);
    endtask
    // run one command, then check result when res_on is set, and the masked flags
    task automatic op(input cfa_pkg::cfa_op_t c, input logic [7:0] a, input logic [7:0] b,
        input logic [7:0] aux, input logic [7:0] res, input logic [7:0] fl,
        input logic [7:0] fm, input logic res_on);
        xfer(1'b1, cfa_pkg::OFF_OPERANDS, {4'h0, c, aux, b, a});
        if (res_on) rdchk(cfa_pkg::OFF_RESULT, {24'h0, res}, 32'hffffffff);
        rdchk(cfa_pkg::OFF_FLAGS, {24'h0, fl}, {24'h0, fm});
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (10) @(posedge core_clk);
        arst_n <= 1'b1;
        @(posedge core_clk);
        rdchk(cfa_pkg::OFF_FLAGS, 32'h0, 32'hffffffff);
        rdchk(cfa_pkg::OFF_ALT_FLAGS, 32'h0, 32'hffffffff);
        xfer(1'b1, cfa_pkg::OFF_FLAGS, 32'hff);
        rdchk(cfa_pkg::OFF_FLAGS, 32'hd7, 32'hffffffff);
        xfer(1'b1, cfa_pkg::OFF_ALT_FLAGS, 32'h01);
        xfer(1'b1, cfa_pkg::OFF_CONTROL, 32'h2);
        rdchk(cfa_pkg::OFF_FLAGS, 32'h01, 32'hff);
        rdchk(cfa_pkg::OFF_ALT_FLAGS, 32'hd7, 32'hff);
        $display("test registers done");
        // arithmetic, logic and rotates, flags accumulate from one to the next
        op(cfa_pkg::OP_ADD, 8'h78, 8'h69, 0, 8'he1, 8'h94, 8'hff, 1);
        op(cfa_pkg::OP_ADD, 8'hff, 8'h01, 0, 8'h00, 8'h51, 8'hff, 1);
        op(cfa_pkg::OP_ADC, 8'h10, 8'h20, 0, 8'h31, 8'h00, 8'hff, 1);
        op(cfa_pkg::OP_SUB, 8'h7f, 8'hc0, 0, 8'hbf, 8'h87, 8'hff, 1);
        op(cfa_pkg::OP_SBC, 8'h10, 8'h01, 0, 8'h0e, 8'h12, 8'hff, 1);
        op(cfa_pkg::OP_SUB, 8'h05, 8'h05, 0, 8'h00, 8'h42, 8'hff, 1);
        op(cfa_pkg::OP_FORCE_CARRY, 0, 0, 0, 0, 8'h01, 8'h01, 0);
        op(cfa_pkg::OP_AND, 8'hf0, 8'h3c, 0, 8'h30, 8'h14, 8'hff, 1);
        op(cfa_pkg::OP_OR, 8'h01, 8'h02, 0, 8'h03, 8'h04, 8'hff, 1);
        op(cfa_pkg::OP_XOR, 8'h80, 8'h00, 0, 8'h80, 8'h80, 8'hff, 1);
        op(cfa_pkg::OP_CMP, 8'h42, 8'h42, 0, 8'h42, 8'h42, 8'hff, 1);
        op(cfa_pkg::OP_ROTL, 8'h81, 0, 8'h00, 8'h03, 8'h05, 8'h05, 1);
        op(cfa_pkg::OP_ROTR, 8'h01, 0, 8'h01, 8'h80, 8'h01, 8'h05, 1);
        op(cfa_pkg::OP_BIT, 8'h08, 0, 8'h03, 0, 8'h00, 8'h40, 0);
        op(cfa_pkg::OP_BIT, 8'h08, 0, 8'h04, 0, 8'h40, 8'h40, 0);
        op(cfa_pkg::OP_INPUT, 8'h00, 0, 0, 0, 8'h40, 8'hc0, 0);
        op(cfa_pkg::OP_INPUT, 8'h80, 0, 0, 0, 8'h80, 8'hc0, 0);
        op(cfa_pkg::OP_BLOCKIO, 0, 8'h01, 0, 8'h00, 8'h42, 8'h42, 1);
        op(cfa_pkg::OP_BLOCKIO, 0, 8'h02, 0, 8'h01, 8'h02, 8'h42, 1);
        op(cfa_pkg::OP_FORCE_CARRY, 0, 0, 0, 0, 8'h01, 8'h01, 0);
        op(cfa_pkg::OP_INVERT_CARRY, 0, 0, 0, 0, 8'h10, 8'h11, 0);
        op(cfa_pkg::OP_INVERT_CARRY, 0, 0, 0, 0, 8'h01, 8'h11, 0);
        // decimal adjust after a plain sum and after one that wraps to zero
        op(cfa_pkg::OP_ADD, 8'h15, 8'h27, 0, 8'h3c, 8'h00, 8'hff, 1);
        xfer(1'b1, cfa_pkg::OFF_CONTROL, 32'h1);
        rdchk(cfa_pkg::OFF_RESULT, 32'h42, 32'hffffffff);
        rdchk(cfa_pkg::OFF_FLAGS, 32'h00, 32'h41);
        op(cfa_pkg::OP_ADD, 8'h99, 8'h01, 0, 8'h9a, 8'h80, 8'hff, 1);
        xfer(1'b1, cfa_pkg::OFF_CONTROL, 32'h1);
        rdchk(cfa_pkg::OFF_FLAGS, 32'h41, 32'h41);
        // result is read-only, unmapped space is refused
        xfer(1'b1, cfa_pkg::OFF_RESULT, 32'hffffffff);
        rdchk(cfa_pkg::OFF_RESULT, 32'h00, 32'hffffffff);
        xfer(1'b1, 8'h24, 32'h5a);
        chk({31'h0, err}, 32'h1, 32'h1);
        rdchk(8'h24, 32'h0, 32'hffffffff);
        $display("test flags done");
        // every condition code against two flag patterns
        for (int f = 0; f < 2; f++) begin
            fv = f ? 8'h45 : 8'h82;
            xfer(1'b1, cfa_pkg::OFF_FLAGS, {24'h0, fv});
            for (int s = 0; s < 8; s++) begin
                cond_sel <= s[2:0];
                xfer(1'b0, cfa_pkg::OFF_FLAGS, 32'h0);
                chk({31'h0, cond_true}, {31'h0, fv[FIDX[s[2:1]]] == s[0]}, 32'h1);
            end
        end
        $display("test conditions done");
        // pair 0x12 high, 0x34 low; instruction bytes low byte first
        xfer(1'b1, cfa_pkg::OFF_PAIR, 32'h3412);
        xfer(1'b1, cfa_pkg::OFF_INSTR, 32'heeabcd28);
        rdchk(cfa_pkg::OFF_INSTR, 32'heeabcd28, 32'hffffffff);
        rdchk(cfa_pkg::OFF_ADDR, 32'habcdabcd, 32'hffffffff);
        rdchk(cfa_pkg::OFF_INFO, 32'h0028cd05, 32'hffffff07);
        xfer(1'b1, cfa_pkg::OFF_INSTR, 32'heeabcd3f);
        rdchk(cfa_pkg::OFF_ADDR, 32'h12341234, 32'hffffffff);
        rdchk(cfa_pkg::OFF_INFO, 32'h0038cd03, 32'hffffff07);
        xfer(1'b1, cfa_pkg::OFF_INSTR, 32'h00abcd02);
        rdchk(cfa_pkg::OFF_ADDR, 32'h1234abcd, 32'hffffffff);
        $display("test addressing done");
        summarize();
    end
endmodule
